//--- hw/speech_codec_homing_pkg.sv
// Notes on behaviour
// - encoder homing frame is 160 equal 13-bit samples with only the LSB set
// - left-justified in 16-bit words each homing sample reads 0008 hex
// - decoder homing frame area ratio codes start 09, 17, 0F, rest fixed
// - every subframe: lag 28 hex, gain/grid/amplitude 0, pulses 4, sub 4 pulse 4 is 3
// - encoder homing counts only when aligned to its own 160-sample frame
// - encoder codes homing frame normally; from home it yields decoder homing frame
// - after an encoder homing frame every encoder sub-module returns home
// - homing reset happens only after the homing frame itself is processed
// - second and later consecutive decoder homing frames give encoder homing output
// - homing is optional and may be switched off entirely
// - pulse codes become levels, scaled by the decoded block maximum
// - 13 pulses upsampled by 3 with zeros, offset by grid code
// - synthesis coefficients rebuilt from area ratio codes, lattice filtering
// - de-emphasis: output is synthesis sample plus previous output times 28180/2^15
// - good decoder homing frame: decode, substitute if home, then reset all state
// - decoder home: lag 40, area ratios, filter and de-emphasis memories zero
// - when home, area ratios plus first subframe suffice to spot a homing frame
`default_nettype none
package speech_codec_homing_pkg;
   // =====================================================================
   // framing
   localparam int FRAME_LEN = 160;
   localparam int SUB_LEN = 40;
   localparam int NUM_LAR = 8;
   localparam int SUB_FIELDS = 17;
   localparam int NUM_PULSES = 13;
   localparam int GRID_STEP = 3;
   localparam int LAST_SUB = 3;
   localparam int FIRST_PULSE_FIELD = 4;
   // =====================================================================
   // homing patterns
   localparam logic [15:0] ENC_HOME_SAMPLE = 16'h0008;
   localparam logic [15:0] SAMPLE_MASK = 16'hFFF8;
   localparam logic [6:0] HOME_LAG = 7'h28;
   localparam logic [2:0] HOME_PULSE = 3'h4;
   localparam logic [2:0] ALT_PULSE = 3'h3;
   localparam logic [4:0] ALT_FIELD = 5'h08;
   localparam logic [5:0] LAR_HOME [0:7] = '{6'h09, 6'h17, 6'h0F, 6'h08,
                                             6'h07, 6'h03, 6'h03, 6'h02};
   localparam int LAR_WIDTH [0:7] = '{6, 6, 5, 5, 4, 4, 3, 3};
   localparam logic [5:0] LAR_MASK [0:7] = '{6'h3F, 6'h3F, 6'h1F, 6'h1F,
                                             6'h0F, 6'h0F, 6'h07, 6'h07};
   // =====================================================================
   // arithmetic constants
   localparam logic [15:0] DEEMPH_BETA = 16'h6E14;
   localparam logic [16:0] LEVEL_STEP_SHIFTED = 17'h02000;
   localparam logic [16:0] LEVEL_OFFSET = 17'h07000;
   localparam logic [5:0] XMAX_LINEAR_LIMIT = 6'h10;
   // =====================================================================
   // reset values
   localparam logic [7:0] ENC_CNT_RESET = 8'h00;
   localparam logic [15:0] MEM_RESET = 16'h0000;
   typedef enum logic [1:0] {
      ST_LOAD = 2'b01,
      ST_EMIT = 2'b10
   } dec_state_e;
endpackage
`default_nettype wire

//--- hw/speech_codec_homing.sv
`timescale 1ns/1ps
`default_nettype none
module speech_codec_homing (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // homing strap, asynchronous pin
   input wire logic homing_enable,
   // encoder sample stream
   input wire logic enc_sample_valid,
   input wire logic [15:0] enc_sample,
   output logic enc_in_home,
   output logic enc_homing_frame,
   output logic enc_home_reset,
   // decoder parameter stream
   input wire logic param_valid,
   input wire logic [6:0] param_data,
   input wire logic frame_bad,
   output logic param_ready,
   // decoder speech output
   output logic speech_valid,
   output logic [15:0] speech_sample,
   output logic [6:0] ltp_lag,
   output logic dec_in_home,
   output logic dec_home_reset
);
   typedef struct packed {
      logic en_s1;
      logic en_s2;
      logic [7:0] enc_cnt;
      logic enc_match;
      logic enc_home;
      logic enc_hpulse;
      logic enc_rpulse;
      speech_codec_homing_pkg::dec_state_e st;
      logic lar_done;
      logic [4:0] fld;
      logic [1:0] sub;
      logic [5:0] k;
      logic dec_match;
      logic subst;
      logic bad;
      logic dec_home;
      logic dec_rpulse;
      logic [7:0][5:0] lar;
      logic [7:0][5:0] lar_prev;
      logic [6:0] lag;
      logic [1:0] grid;
      logic [5:0] xmax;
      logic [12:0][2:0] pulse;
      logic [8:0][15:0] v;
      logic [15:0] deemph;
      logic [15:0] out;
      logic out_valid;
   } state_s;

   state_s state_reg;
   state_s state_next;

   // =====================================================================
   // fixed-point helpers
   function automatic logic [15:0] add_sat(input logic [15:0] a, input logic [15:0] b);
      logic signed [16:0] s;
      s = $signed({a[15], a}) + $signed({b[15], b});
      if (s > 17'sh07FFF)
         add_sat = 16'h7FFF;
      else if (s < -17'sh08000)
         add_sat = 16'h8000;
      else
         add_sat = s[15:0];
   endfunction

   function automatic logic [15:0] sub_sat(input logic [15:0] a, input logic [15:0] b);
      logic signed [16:0] s;
      s = $signed({a[15], a}) - $signed({b[15], b});
      if (s > 17'sh07FFF)
         sub_sat = 16'h7FFF;
      else if (s < -17'sh08000)
         sub_sat = 16'h8000;
      else
         sub_sat = s[15:0];
   endfunction

   function automatic logic [15:0] mult_r(input logic [15:0] a, input logic [15:0] b);
      logic signed [31:0] p;
      p = $signed(a) * $signed(b) + 32'sd16384;
      if (a == 16'h8000 && b == 16'h8000)
         mult_r = 16'h7FFF;
      else
         mult_r = p[30:15];
   endfunction

   // =====================================================================
   // synthesis coefficients; first subframe blends previous frame's codes
   logic [15:0] coef [0:7];
   genvar g;
   generate
      for (g = 0; g < speech_codec_homing_pkg::NUM_LAR; g++)
      begin : g_coef
         localparam int W = speech_codec_homing_pkg::LAR_WIDTH[g];
         logic [6:0] sum;
         logic [15:0] code;
         assign sum = {1'b0, state_reg.lar[g]} + {1'b0, state_reg.lar_prev[g]};
         assign code = (state_reg.sub == 2'h0) ? {10'h000, sum[6:1]}
                                               : {10'h000, state_reg.lar[g]};
         // centred code shifted left by 16 - W to full 16-bit range
         assign coef[g] = 16'((code - (16'h0001 << (W - 1))) << (16 - W));
      end
   endgenerate

   // =====================================================================
   // next-state logic
   always_comb
   begin
      logic hit;
      logic [6:0] expv;
      logic [5:0] rel;
      logic [3:0] pidx;
      logic on_grid;
      logic [15:0] xmaxp;
      logic [4:0] mant_e;
      logic signed [16:0] level;
      logic signed [33:0] prod;
      logic [15:0] er;
      logic [15:0] sri;
      logic [15:0] y;
      hit = 1'b0;
      expv = 7'h00;
      rel = 6'h00;
      pidx = 4'h0;
      on_grid = 1'b0;
      xmaxp = 16'h0000;
      mant_e = 5'h00;
      level = 17'sh00000;
      prod = 34'sh0;
      er = 16'h0000;
      sri = 16'h0000;
      y = 16'h0000;
      state_next = state_reg;
      state_next.en_s1 = homing_enable;
      state_next.en_s2 = state_reg.en_s1;
      state_next.enc_hpulse = 1'b0;
      state_next.enc_rpulse = 1'b0;
      state_next.dec_rpulse = 1'b0;
      state_next.out_valid = 1'b0;

      // ---- encoder homing: count own frame boundaries only
      if (enc_sample_valid)
      begin
         // low three bits are not part of the 13-bit sample
         hit = (enc_sample & speech_codec_homing_pkg::SAMPLE_MASK)
               == speech_codec_homing_pkg::ENC_HOME_SAMPLE;
         if (state_reg.enc_cnt == 8'(speech_codec_homing_pkg::FRAME_LEN - 1))
         begin
            state_next.enc_cnt = speech_codec_homing_pkg::ENC_CNT_RESET;
            state_next.enc_match = 1'b1;
            if (state_reg.en_s2 && state_reg.enc_match && hit)
            begin
               // last sample already handed to the coder: reset afterwards
               state_next.enc_home = 1'b1;
               state_next.enc_hpulse = 1'b1;
               state_next.enc_rpulse = 1'b1;
            end
            else
               state_next.enc_home = 1'b0;
         end
         else
         begin
            state_next.enc_cnt = state_reg.enc_cnt + 8'h01;
            state_next.enc_match = state_reg.enc_match & hit;
         end
      end

      // ---- expected decoder homing parameter for this slot
      if (!state_reg.lar_done)
         expv = {1'b0, speech_codec_homing_pkg::LAR_HOME[state_reg.fld[2:0]]};
      else if (state_reg.fld == 5'h00)
         expv = speech_codec_homing_pkg::HOME_LAG;
      else if (state_reg.fld < 5'(speech_codec_homing_pkg::FIRST_PULSE_FIELD))
         expv = 7'h00;
      else if (state_reg.sub == 2'(speech_codec_homing_pkg::LAST_SUB)
               && state_reg.fld == speech_codec_homing_pkg::ALT_FIELD)
         expv = {4'h0, speech_codec_homing_pkg::ALT_PULSE};
      else
         expv = {4'h0, speech_codec_homing_pkg::HOME_PULSE};

      // ---- RPE reconstruction for sample k of the subframe
      if (state_reg.k >= {4'h0, state_reg.grid})
         rel = state_reg.k - {4'h0, state_reg.grid};
      pidx = 4'(rel / 6'(speech_codec_homing_pkg::GRID_STEP));
      on_grid = (state_reg.k >= {4'h0, state_reg.grid})
                && (rel % 6'(speech_codec_homing_pkg::GRID_STEP) == 6'h00)
                && (pidx < 4'(speech_codec_homing_pkg::NUM_PULSES));
      if (state_reg.xmax < speech_codec_homing_pkg::XMAX_LINEAR_LIMIT)
         xmaxp = {5'h00, state_reg.xmax, 5'h1F};
      else
      begin
         mant_e = {2'b00, state_reg.xmax[2:0]} + 5'h09; // five bits: low code 7 gives 16
         xmaxp = ({11'h000, mant_e} << ({1'b0, state_reg.xmax[5:3]} + 4'h4)) - 16'h0001;
      end
      if (pidx < 4'(speech_codec_homing_pkg::NUM_PULSES))
         level = $signed({14'h0000, state_reg.pulse[pidx]}
                         * speech_codec_homing_pkg::LEVEL_STEP_SHIFTED)
                 - $signed(speech_codec_homing_pkg::LEVEL_OFFSET);
      prod = level * $signed({1'b0, xmaxp});
      if (on_grid)
         er = prod[30:15];

      // ---- lattice synthesis and de-emphasis
      sri = er;
      for (int i = 8; i >= 1; i--)
      begin
         sri = sub_sat(sri, mult_r(coef[i - 1], state_reg.v[i - 1]));
         state_next.v[i] = add_sat(state_reg.v[i - 1], mult_r(coef[i - 1], sri));
      end
      y = add_sat(sri, mult_r(state_reg.deemph, speech_codec_homing_pkg::DEEMPH_BETA));

      case (state_reg.st)
         speech_codec_homing_pkg::ST_LOAD:
         begin
            state_next.v = state_reg.v;
            if (param_valid)
            begin
               state_next.dec_match = state_reg.dec_match & (param_data == expv);
               if (!state_reg.lar_done)
               begin
                  state_next.lar[state_reg.fld[2:0]] = param_data[5:0]
                     & speech_codec_homing_pkg::LAR_MASK[state_reg.fld[2:0]];
                  state_next.lar_done = (state_reg.fld == 5'h07);
                  state_next.fld = (state_reg.fld == 5'h07) ? 5'h00 : state_reg.fld + 5'h01;
               end
               else
               begin
                  case (state_reg.fld)
                     5'h00: state_next.lag = param_data;
                     5'h02: state_next.grid = param_data[1:0];
                     5'h03: state_next.xmax = param_data[5:0];
                     default:
                     begin
                        if (state_reg.fld >= 5'(speech_codec_homing_pkg::FIRST_PULSE_FIELD))
                           state_next.pulse[state_reg.fld - 5'h04] = param_data[2:0];
                     end
                  endcase
                  if (state_reg.fld == 5'(speech_codec_homing_pkg::SUB_FIELDS - 1))
                  begin
                     state_next.fld = 5'h00;
                     state_next.k = 6'h00;
                     state_next.bad = frame_bad;
                     state_next.st = speech_codec_homing_pkg::ST_EMIT;
                     // from home, area ratios and first subframe decide early
                     if (state_reg.sub == 2'h0)
                        state_next.subst = state_reg.dec_home & state_reg.en_s2
                                           & state_next.dec_match;
                  end
                  else
                     state_next.fld = state_reg.fld + 5'h01;
               end
            end
         end
         speech_codec_homing_pkg::ST_EMIT:
         begin
            state_next.v[0] = sri;
            state_next.deemph = y;
            state_next.out_valid = 1'b1;
            state_next.out = state_reg.subst ? speech_codec_homing_pkg::ENC_HOME_SAMPLE
                             : (y & speech_codec_homing_pkg::SAMPLE_MASK);
            if (state_reg.k == 6'(speech_codec_homing_pkg::SUB_LEN - 1))
            begin
               state_next.st = speech_codec_homing_pkg::ST_LOAD;
               if (state_reg.sub == 2'(speech_codec_homing_pkg::LAST_SUB))
               begin
                  state_next.sub = 2'h0;
                  state_next.lar_done = 1'b0;
                  state_next.dec_match = 1'b1;
                  state_next.subst = 1'b0;
                  // whole frame decoded before state is sent home
                  if (state_reg.en_s2 && state_reg.dec_match && !state_reg.bad)
                  begin
                     state_next.lar_prev = '0;
                     state_next.v = '0;
                     state_next.deemph = speech_codec_homing_pkg::MEM_RESET;
                     state_next.lag = speech_codec_homing_pkg::HOME_LAG;
                     state_next.dec_home = 1'b1;
                     state_next.dec_rpulse = 1'b1;
                  end
                  else
                  begin
                     state_next.lar_prev = state_reg.lar;
                     state_next.dec_home = 1'b0;
                  end
               end
               else
                  state_next.sub = state_reg.sub + 2'h1;
            end
            else
               state_next.k = state_reg.k + 6'h01;
         end
         default:
            state_next.st = speech_codec_homing_pkg::ST_LOAD;
      endcase
   end

   // =====================================================================
   // state register; both sides start in home state
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_reg <= '0;
         state_reg.enc_match <= 1'b1;
         state_reg.enc_home <= 1'b1;
         state_reg.dec_match <= 1'b1;
         state_reg.dec_home <= 1'b1;
         state_reg.lag <= speech_codec_homing_pkg::HOME_LAG;
         state_reg.st <= speech_codec_homing_pkg::ST_LOAD;
      end
      else
         state_reg <= state_next;
   end

   // =====================================================================
   // outputs; params stall while a subframe is being emitted
   assign param_ready = (state_reg.st == speech_codec_homing_pkg::ST_LOAD);
   assign enc_in_home = state_reg.enc_home;
   assign enc_homing_frame = state_reg.enc_hpulse;
   assign enc_home_reset = state_reg.enc_rpulse;
   assign speech_valid = state_reg.out_valid;
   assign speech_sample = state_reg.out;
   assign ltp_lag = state_reg.lag;
   assign dec_in_home = state_reg.dec_home;
   assign dec_home_reset = state_reg.dec_rpulse;
endmodule // speech_codec_homing
`default_nettype wire

//--- tb/homing_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module homing_checker (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // encoder side
   input wire logic homing_enable,
   input wire logic enc_sample_valid,
   input wire logic [15:0] enc_sample,
   input wire logic enc_in_home,
   input wire logic enc_homing_frame,
   input wire logic enc_home_reset,
   // decoder side
   input wire logic param_valid,
   input wire logic [6:0] param_data,
   input wire logic frame_bad,
   input wire logic param_ready,
   input wire logic speech_valid,
   input wire logic [15:0] speech_sample,
   input wire logic [6:0] ltp_lag,
   input wire logic dec_in_home,
   input wire logic dec_home_reset
);
   // =====
   // burst length counter, a repetition cannot reach 40
   logic [5:0] burst_reg;
   logic [5:0] burst_next;
   always_comb
   begin
      burst_next = param_ready ? 6'h00 : burst_reg + {5'h00, speech_valid};
   end
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         burst_reg <= 6'h00;
      else
         burst_reg <= burst_next;
   end
   // =====
   // properties
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);
   sequence emit_start;
      $fell(param_ready);
   endsequence
   sequence emit_run;
      speech_valid [*8];
   endsequence
   enc_pair_a: assert property (enc_homing_frame |-> enc_home_reset && enc_in_home)
      else $error("encoder homing pulse without reset pulse or home flag");
   enc_single_a: assert property (enc_homing_frame |=> !enc_homing_frame)
      else $error("encoder homing pulse longer than one cycle");
   enc_cause_a: assert property (enc_homing_frame |-> $past(enc_sample[15:3]) == 13'h0001)
      else $error("encoder homing pulse after a non homing sample");
   enc_set_a: assert property ($rose(enc_in_home) |-> enc_homing_frame)
      else $error("encoder home flag set without homing frame");
   enc_clear_a: assert property ($fell(enc_in_home) |-> $past(enc_sample_valid))
      else $error("encoder home flag cleared away from a frame end");
   dec_reset_a: assert property (dec_home_reset |-> dec_in_home ##1 ltp_lag == 7'h28)
      else $error("decoder home state not entered on homing");
   dec_set_a: assert property ($rose(dec_in_home) |-> dec_home_reset)
      else $error("decoder home flag set without reset pulse");
   emit_burst_a: assert property (emit_start |=> emit_run)
      else $error("speech burst does not start right after ready drops");
   emit_count_a: assert property ($rose(param_ready) |-> speech_valid && burst_reg == 6'h27)
      else $error("speech burst is not 40 samples");
   speech_bits_a: assert property (speech_valid |-> speech_sample[2:0] == 3'h0)
      else $error("speech sample not left justified");
endmodule // homing_checker
bind speech_codec_homing homing_checker u_homing_checker (
   .ref_clk(ref_clk), .reset_n(reset_n), .homing_enable(homing_enable),
   .enc_sample_valid(enc_sample_valid), .enc_sample(enc_sample), .enc_in_home(enc_in_home),
   .enc_homing_frame(enc_homing_frame), .enc_home_reset(enc_home_reset),
   .param_valid(param_valid), .param_data(param_data), .frame_bad(frame_bad),
   .param_ready(param_ready), .speech_valid(speech_valid), .speech_sample(speech_sample),
   .ltp_lag(ltp_lag), .dec_in_home(dec_in_home), .dec_home_reset(dec_home_reset)
);
`default_nettype wire

//--- tb/param_channel_model.sv
`timescale 1ns/1ps
`default_nettype none
module param_channel_model (
   // clock
   input wire logic ref_clk,
   // parameter channel
   input wire logic param_ready,
   output logic param_valid,
   output logic [6:0] param_data,
   output logic frame_bad,
   // sample source
   output logic enc_sample_valid,
   output logic [15:0] enc_sample,
   // wait bound used up
   output logic timed_out
);
   initial
   begin
      param_valid = 1'b0;
      param_data = 7'h00;
      frame_bad = 1'b0;
      enc_sample_valid = 1'b0;
      enc_sample = 16'h0000;
      timed_out = 1'b0;
   end
   // =====
   // frame words; alt moves the last lag off the homing value
   function automatic logic [6:0] home_word(input int i, input bit alt);
      int f;
      int sub;
      f = (i - 8) % 17;
      sub = (i - 8) / 17;
      if (i < 8)
         return {1'b0, speech_codec_homing_pkg::LAR_HOME[i]};
      if (f == 0)
         return (alt && sub == 3) ? 7'h29 : 7'h28;
      if (f < 4)
         return 7'h00;
      return (sub == 3 && f == 8) ? 7'h03 : 7'h04;
   endfunction
   task automatic put_word(input logic [6:0] w, input logic bad);
      int n;
      n = 0;
      param_valid <= 1'b1;
      param_data <= w;
      frame_bad <= bad;
      @(posedge ref_clk);
      while (param_ready !== 1'b1 && n < 100)
      begin
         n++;
         @(posedge ref_clk);
      end
      if (n == 100)
         timed_out <= 1'b1;
   endtask
   task automatic send_dec_frame(input bit alt, input bit bad);
      int n;
      n = 0;
      for (int i = 0; i < 76; i++)
         put_word(home_word(i, alt), bad);
      // released lines show the inverse so stale data is never read as good
      param_valid <= 1'b0;
      param_data <= ~param_data;
      frame_bad <= ~bad;
      repeat (2) @(posedge ref_clk);
      while (param_ready !== 1'b1 && n < 60)
      begin
         n++;
         @(posedge ref_clk);
      end
      if (n == 60)
         timed_out <= 1'b1;
   endtask
   // rel lowers the strobe; back to back calls keep it high
   task automatic send_samples(input logic [15:0] s, input int cnt, input bit rel);
      for (int i = 0; i < cnt; i++)
      begin
         enc_sample_valid <= 1'b1;
         enc_sample <= s;
         @(posedge ref_clk);
      end
      if (rel)
      begin
         enc_sample_valid <= 1'b0;
         enc_sample <= ~s;
      end
   endtask
endmodule // param_channel_model
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic ref_clk;
   logic reset_n;
   logic homing_enable;
   logic enc_sample_valid;
   logic [15:0] enc_sample;
   logic param_valid;
   logic [6:0] param_data;
   logic frame_bad;
   logic timed_out;
   logic enc_in_home, enc_homing_frame, enc_home_reset, param_ready, speech_valid;
   logic [15:0] speech_sample;
   logic [6:0] ltp_lag;
   logic dec_in_home, dec_home_reset;
   int mismatches = 0;
   int check_count = 0;
   int sp_cnt = 0;
   int sp_other = 0;
   int enc_pulses = 0;
   int dec_pulses = 0;
   // =====
   // structure
   speech_codec_homing DUT (
      .ref_clk(ref_clk), .reset_n(reset_n), .homing_enable(homing_enable),
      .enc_sample_valid(enc_sample_valid), .enc_sample(enc_sample), .enc_in_home(enc_in_home),
      .enc_homing_frame(enc_homing_frame), .enc_home_reset(enc_home_reset),
      .param_valid(param_valid), .param_data(param_data), .frame_bad(frame_bad),
      .param_ready(param_ready), .speech_valid(speech_valid), .speech_sample(speech_sample),
      .ltp_lag(ltp_lag), .dec_in_home(dec_in_home), .dec_home_reset(dec_home_reset)
   );
   param_channel_model partner (
      .ref_clk(ref_clk), .param_ready(param_ready), .param_valid(param_valid),
      .param_data(param_data), .frame_bad(frame_bad), .enc_sample_valid(enc_sample_valid),
      .enc_sample(enc_sample), .timed_out(timed_out)
   );
   initial
   begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
   begin
      if (speech_valid === 1'b1)
         sp_cnt++;
      if (speech_valid === 1'b1 && speech_sample !== 16'h0008)
         sp_other++;
      if (enc_homing_frame === 1'b1)
         enc_pulses++;
      if (dec_home_reset === 1'b1)
         dec_pulses++;
      if (timed_out === 1'b1)
      begin
         mismatches++;
         print_verdict();
      end
   end
   // =====
   // shared tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic do_reset();
      reset_n <= 1'b0;
      repeat (16) @(posedge ref_clk);
      check(16'(enc_in_home), 16'h0001);
      check(16'(dec_in_home), 16'h0001);
      check(16'(ltp_lag), 16'h0028);
      check(16'(param_ready), 16'h0001);
      reset_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
   endtask
   task automatic dec_frame(input bit alt, input bit bad);
      sp_cnt = 0;
      sp_other = 0;
      partner.send_dec_frame(alt, bad);
      @(posedge ref_clk);
   endtask
   // =====
   // scenarios
   task automatic enc_home_scn();
      partner.send_samples(16'h000D, 160, 1'b1);
      repeat (3) @(posedge ref_clk);
      check(16'(enc_pulses), 16'h0001);
      check(16'(enc_in_home), 16'h0001);
   endtask
   task automatic enc_break_scn();
      partner.send_samples(16'h0008, 159, 1'b0);
      partner.send_samples(16'h0010, 1, 1'b1);
      repeat (3) @(posedge ref_clk);
      check(16'(enc_pulses), 16'h0001);
      check(16'(enc_in_home), 16'h0000);
      partner.send_samples(16'h0008, 160, 1'b1);
      repeat (3) @(posedge ref_clk);
      check(16'(enc_pulses), 16'h0002);
      check(16'(enc_in_home), 16'h0001);
   endtask
   task automatic enc_shift_scn();
      partner.send_samples(16'h0000, 80, 1'b0);
      partner.send_samples(16'h0008, 160, 1'b0);
      partner.send_samples(16'h0000, 80, 1'b1);
      repeat (3) @(posedge ref_clk);
      check(16'(enc_pulses), 16'h0002);
      check(16'(enc_in_home), 16'h0000);
   endtask
   task automatic dec_home_scn();
      dec_frame(1'b0, 1'b0);
      check(16'(sp_cnt), 16'h00A0);
      check(16'(sp_other), 16'h0000);
      check(16'(dec_pulses), 16'h0001);
      check(16'(dec_in_home), 16'h0001);
      check(16'(ltp_lag), 16'h0028);
   endtask
   task automatic dec_partial_scn();
      dec_frame(1'b1, 1'b0);
      check(16'(sp_other), 16'h0000);
      check(16'(dec_pulses), 16'h0001);
      check(16'(dec_in_home), 16'h0000);
      check(16'(ltp_lag), 16'h0029);
   endtask
   task automatic dec_run_scn();
      dec_frame(1'b0, 1'b0);
      check(16'(dec_pulses), 16'h0002);
      check(16'(dec_in_home), 16'h0001);
      check(16'(ltp_lag), 16'h0028);
      dec_frame(1'b0, 1'b0);
      check(16'(sp_cnt), 16'h00A0);
      check(16'(sp_other), 16'h0000);
   endtask
   task automatic dec_bad_scn();
      dec_frame(1'b0, 1'b1);
      check(16'(dec_pulses), 16'h0003);
      check(16'(dec_in_home), 16'h0000);
   endtask
   task automatic strap_off_scn();
      homing_enable <= 1'b0;
      do_reset();
      partner.send_samples(16'h0008, 160, 1'b1);
      repeat (3) @(posedge ref_clk);
      check(16'(enc_pulses), 16'h0002);
      check(16'(enc_in_home), 16'h0000);
      dec_frame(1'b0, 1'b0);
      check(16'(dec_pulses), 16'h0003);
      check(16'(dec_in_home), 16'h0000);
   endtask
   initial
   begin
      reset_n = 1'b0;
      homing_enable = 1'b1;
      do_reset();
      enc_home_scn();
      enc_break_scn();
      enc_shift_scn();
      dec_home_scn();
      dec_partial_scn();
      dec_run_scn();
      dec_bad_scn();
      strap_off_scn();
      print_verdict();
   end
endmodule // tb_top
`default_nettype wire
